/* fccd_decoder.sv */
`default_nettype none
`include "fccd_cfg.svh"
module fccd_decoder
  import fccd_pkg::*;
#(
  parameter logic [7:0]  MANUF_ID  = 8'hA5,    // Arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h5A_3C  // Arbitrary value
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       hwResetN,
  input  wire logic       chipSelectN,
  input  wire logic       serialClk,
  input  wire logic [3:0] quadIoIn,
  input  wire logic       quadCommandMode,
  input  wire logic       pgmEraseBusy,
  output logic            serialOut,
  output logic            serialOutEn,
  output logic            writeLatch,
  output logic            boostActive,
  output logic            softResetPulse,
  output logic            cmdValid,
  output logic [7:0]      cmdOpcode,
  output logic            cmdBoosted
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] ioMeta_reg;
  logic [3:0] ioSync_reg;
  logic [2:0] pinMeta_reg;
  logic [2:0] pinSync_reg;
  logic       sclkLast_reg;
  always_ff @(posedge clk) begin
    ioMeta_reg  <= quadIoIn;
    ioSync_reg  <= ioMeta_reg;
    pinMeta_reg <= {chipSelectN, serialClk, hwResetN};
    pinSync_reg <= pinMeta_reg;
    sclkLast_reg <= pinSync_reg[1];
  end

  wire csN       = pinSync_reg[2];
  wire sclk      = pinSync_reg[1];
  wire hwRstN    = pinSync_reg[0];
  wire sclkRise  = sclk & ~sclkLast_reg;
  wire sclkFall  = ~sclk & sclkLast_reg;
  wire anyReset  = sys_rst | ~hwRstN;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode capture
  fccd_state_type state_reg;
  fccd_state_type state_next;
  logic [7:0]     shift_reg;
  logic [3:0]     bitCnt_reg;
  logic [4:0]     idCnt_reg;
  logic [23:0]    idShift_reg;
  fccd_flags_type flags_reg;
  fccd_flags_type flags_next;
  logic           quadLatched_reg;

  wire [7:0] shiftSpi  = {shift_reg[6:0], ioSync_reg[0]};
  wire [7:0] shiftQuad = {shift_reg[3:0], ioSync_reg};
  wire [7:0] shiftNew  = quadLatched_reg ? shiftQuad : shiftSpi;
  wire [3:0] opClks    = quadLatched_reg ? `FCCD_QUAD_CLKS : `FCCD_SPI_CLKS;
  wire       opDone    = (state_reg == FCCD_OPCODE) && sclkRise && !csN
                         && (bitCnt_reg == opClks - 4'd1);
  wire [7:0] op        = shiftNew;

  wire isProgErase = (op == `FCCD_OP_PAGE_PGM) || (op == `FCCD_OP_QPAGE_PGM)
                  || (op == `FCCD_OP_SECT_WIPE) || (op == `FCCD_OP_BLK32_WIPE)
                  || (op == `FCCD_OP_BLK64_WIPE) || (op == `FCCD_OP_CHIP_WIPE);
  wire isContent   = isProgErase || (op == `FCCD_OP_STAT_WR);
  // Shared code: boost wins over scheme pick
  wire isBoost     = (op == `FCCD_OP_BOOST);
  wire isLatchClr  = isContent || (op == `FCCD_OP_LOCK_WR)
                  || (op == `FCCD_OP_ARR_LOCK) || (op == `FCCD_OP_ARR_UNLOCK)
                  || (op == `FCCD_OP_PROT_PICK);
  // id only in SPI and when idle
  wire idAccept    = (op == `FCCD_OP_ID_QUERY) && !quadLatched_reg && !pgmEraseBusy;
  wire fireOk      = (op == `FCCD_OP_RST_FIRE) && flags_reg.resetArmed;
  wire pauseOk     = (op == `FCCD_OP_PAUSE) && !flags_reg.boostActive;
  wire contentOk   = isContent && flags_reg.writeLatch;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FCCD_IDLE:   if (!csN) state_next = FCCD_OPCODE;
      FCCD_OPCODE: if (csN) state_next = FCCD_IDLE;
                   else if (opDone) state_next = idAccept ? FCCD_IDOUT : FCCD_IGNORE;
      FCCD_IDOUT:  if (csN) state_next = FCCD_IDLE;
      FCCD_IGNORE: if (csN) state_next = FCCD_IDLE;
    endcase
  end

  always_comb begin
    flags_next = flags_reg;
    if (opDone) begin
      flags_next.resetArmed = (op == `FCCD_OP_RST_ARM);
      if (op == `FCCD_OP_WR_ARM) flags_next.writeLatch = 1'b1;
      if ((op == `FCCD_OP_WR_DISARM) || pauseOk || fireOk
          || (isLatchClr && !isBoost && flags_reg.writeLatch)) flags_next.writeLatch = 1'b0;
      if (isBoost && flags_reg.writeLatch) flags_next.boostActive = 1'b1;
      if ((isProgErase && flags_reg.writeLatch) || fireOk) flags_next.boostActive = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg       <= FCCD_IDLE;
      shift_reg       <= 8'h00;
      bitCnt_reg      <= 4'h0;
      quadLatched_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == FCCD_IDLE) begin
        bitCnt_reg      <= 4'h0;
        quadLatched_reg <= quadCommandMode;
      end else if (state_reg == FCCD_OPCODE && sclkRise) begin
        shift_reg  <= shiftNew;
        bitCnt_reg <= bitCnt_reg + 4'd1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (anyReset) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ID output and command strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idShift_reg    <= 24'h0000_00;
      idCnt_reg      <= 5'h00;
      serialOut      <= 1'b0;
      serialOutEn    <= 1'b0;
      softResetPulse <= 1'b0;
      cmdValid       <= 1'b0;
      cmdOpcode      <= 8'h00;
      cmdBoosted     <= 1'b0;
    end else begin
      softResetPulse <= opDone && fireOk;
      cmdValid       <= opDone && (contentOk || pauseOk);
      cmdOpcode      <= opDone ? op : cmdOpcode;
      // boost only on an allowed command
      cmdBoosted     <= opDone && isProgErase && flags_reg.writeLatch
                        && flags_reg.boostActive;
      if (opDone && idAccept) begin
        idShift_reg <= {MANUF_ID, DEVICE_ID};
        idCnt_reg   <= 5'h00;
      end
      // shift ID out MSB first on falling edge
      if (state_reg == FCCD_IDOUT && !csN && sclkFall && idCnt_reg < `FCCD_ID_BITS) begin
        serialOut   <= idShift_reg[23];
        serialOutEn <= 1'b1;
        idShift_reg <= {idShift_reg[22:0], 1'b0};
        idCnt_reg   <= idCnt_reg + 5'd1;
      end else if (csN || state_reg != FCCD_IDOUT) begin
        serialOutEn <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      writeLatch  <= 1'b0;
      boostActive <= 1'b0;
    end else begin
      writeLatch  <= flags_reg.writeLatch;
      boostActive <= flags_reg.boostActive;
    end
  end
endmodule
`default_nettype wire

/* fccd_cfg.svh */
`ifndef FCCD_CFG_SVH
`define FCCD_CFG_SVH
// Opcodes
`define FCCD_OP_IDLE       8'h00
`define FCCD_OP_RST_ARM    8'h66
`define FCCD_OP_RST_FIRE   8'h99
`define FCCD_OP_WR_ARM     8'h06
`define FCCD_OP_WR_DISARM  8'h04
`define FCCD_OP_BOOST      8'h68
`define FCCD_OP_ID_QUERY   8'h9F
`define FCCD_OP_PAGE_PGM   8'h02
`define FCCD_OP_QPAGE_PGM  8'h38
`define FCCD_OP_SECT_WIPE  8'h20
`define FCCD_OP_BLK32_WIPE 8'h52
`define FCCD_OP_BLK64_WIPE 8'hD8
`define FCCD_OP_CHIP_WIPE  8'h60
`define FCCD_OP_STAT_WR    8'h01
`define FCCD_OP_PAUSE      8'hB0
`define FCCD_OP_LOCK_WR    8'h2F
`define FCCD_OP_PROT_PICK  8'h68
`define FCCD_OP_ARR_LOCK   8'h7E
`define FCCD_OP_ARR_UNLOCK 8'h98
// Opcode clocks per mode
`define FCCD_SPI_CLKS      4'd8
`define FCCD_QUAD_CLKS     4'd2
// ID field widths
`define FCCD_ID_BITS       5'd24
`endif

/* fccd_pkg.sv */
`default_nettype none
package fccd_pkg;
  typedef enum logic [1:0] {
    FCCD_IDLE,
    FCCD_OPCODE,
    FCCD_IDOUT,
    FCCD_IGNORE
  } fccd_state_type;

  typedef struct packed {
    logic       writeLatch;
    logic       boostActive;
    logic       resetArmed;
  } fccd_flags_type;

  typedef struct packed {
    logic [7:0] opcode;
    logic       valid;
  } fccd_cmd_type;
endpackage
`default_nettype wire

/* fccd_decoder_checker.sv */
`default_nettype none
module fccd_decoder_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic hwResetN,
  input wire logic chipSelectN,
  input wire logic quadCommandMode,
  input wire logic pgmEraseBusy,
  input wire logic serialOutEn,
  input wire logic writeLatch,
  input wire logic boostActive,
  input wire logic cmdValid,
  input wire logic cmdBoosted,
  input wire logic softResetPulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  deselect_off_a: assert property (chipSelectN [*6] |-> !serialOutEn)
    else $error("output driven after deselect");
  quad_no_id_a: assert property (quadCommandMode [*8] |-> !serialOutEn)
    else $error("id output in quad mode");
  busy_no_id_a: assert property (pgmEraseBusy [*8] |-> !serialOutEn)
    else $error("id output while busy");
  pin_clear_a: assert property (!hwResetN [*8] |-> !writeLatch && !boostActive)
    else $error("flags kept under reset pin");
  valid_pulse_a: assert property (cmdValid |=> !cmdValid)
    else $error("command pulse too long");
  fire_pulse_a: assert property (softResetPulse |=> !softResetPulse)
    else $error("reset pulse too long");
  boost_valid_a: assert property (cmdBoosted |-> cmdValid)
    else $error("boost without command");
  latch_drop_a: assert property (cmdValid |-> ##[0:6] !writeLatch)
    else $error("latch kept after command");
  boost_drop_a: assert property (cmdBoosted |-> ##[0:6] !boostActive)
    else $error("boost kept after command");
  cover property (cmdBoosted);
  cover property (softResetPulse);
  cover property (serialOutEn ##1 chipSelectN);
endmodule
`default_nettype wire

/* fccd_host.sv */
`default_nettype none
module fccd_host (
  input  wire logic       clk,
  input  wire logic       so,
  output logic            csN,
  output logic            sclk,
  output logic [3:0]      io
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    io = 4'h0;
  end
  task automatic frame(input logic [7:0] op, input logic qd, input int n, input int r,
                       output logic [23:0] rd);
    logic [7:0] sh;
    sh = op;
    rd = 24'h00_0000;
    @(posedge clk);
    csN <= 1'b0;
    for (int i = 0; i < n + r; i++) begin
      io <= qd ? sh[7:4] : {~io[3:1], sh[7]};
      sh = qd ? sh << 4 : sh << 1;
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      if (i >= n) rd = {rd[22:0], so};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    csN <= 1'b1;
    repeat (10) @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* tb_fccd_decoder.sv */
`default_nettype none
`include "fccd_cfg.svh"
module tb_fccd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] ID = 24'h3E_71B4;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic        hwResetN = 1'b1;
  logic        quad = 1'b0;
  logic        busy = 1'b0;
  logic        csN, sclk, so, soEn, latch, boost, srp, cv, cb;
  logic [3:0]  io;
  logic [7:0]  op;
  logic [23:0] rd;
  int          err_count = 0, checked = 0, nV = 0, nR = 0, nB = 0, nE = 0, cyc = 0;
  always #10 clk = ~clk;
  fccd_host u_host (.clk(clk), .so(so), .csN(csN), .sclk(sclk), .io(io));
  fccd_decoder #(.MANUF_ID(8'h3E), .DEVICE_ID(16'h71B4)) u_dut (
    .clk(clk), .sys_rst(sysRst), .hwResetN(hwResetN), .chipSelectN(csN), .serialClk(sclk),
    .quadIoIn(io), .quadCommandMode(quad), .pgmEraseBusy(busy), .serialOut(so),
    .serialOutEn(soEn), .writeLatch(latch), .boostActive(boost), .softResetPulse(srp),
    .cmdValid(cv), .cmdOpcode(op), .cmdBoosted(cb));
  always @(negedge clk) begin
    nV += cv;
    nR += srp;
    nB += cb;
    nE += soEn;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] o);
    u_host.frame(o, quad, quad ? 2 : 8, 0, rd);
  endtask
  task automatic clr();
    nV = 0;
    nR = 0;
    nB = 0;
    nE = 0;
  endtask
  task automatic t_latch();
    cmd(`FCCD_OP_WR_ARM);
    chk(latch, 1);
    cmd(`FCCD_OP_WR_DISARM);
    chk(latch, 0);
    u_host.frame(`FCCD_OP_WR_ARM, 1'b0, 5, 0, rd);
    chk(latch, 0);
    quad <= 1'b1;
    @(posedge clk);
    cmd(`FCCD_OP_WR_ARM);
    chk(latch, 1);
    cmd(`FCCD_OP_WR_DISARM);
    chk(latch, 0);
    quad <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_content();
    logic [7:0] ops [7] = '{8'h02, 8'h38, 8'h20, 8'h52, 8'hD8, 8'h60, 8'h01};
    foreach (ops[i]) begin
      clr();
      cmd(ops[i]);
      chk(nV, 0);
      cmd(`FCCD_OP_WR_ARM);
      cmd(ops[i]);
      chk(nV, 1);
      chk(op, ops[i]);
      chk(latch, 0);
    end
  endtask
  task automatic t_reset();
    clr();
    cmd(`FCCD_OP_RST_FIRE);
    chk(nR, 0);
    cmd(`FCCD_OP_RST_ARM);
    cmd(`FCCD_OP_RST_FIRE);
    chk(nR, 1);
    cmd(`FCCD_OP_RST_ARM);
    cmd(`FCCD_OP_IDLE);
    cmd(`FCCD_OP_RST_FIRE);
    chk(nR, 1);
  endtask
  task automatic t_boost();
    cmd(`FCCD_OP_WR_ARM);
    cmd(`FCCD_OP_BOOST);
    chk(boost, 1);
    clr();
    cmd(`FCCD_OP_PAUSE);
    chk(nV, 0);
    chk(latch, 1);
    cmd(`FCCD_OP_SECT_WIPE);
    chk(nV, 1);
    chk(nB, 1);
    chk(op, `FCCD_OP_SECT_WIPE);
    chk(boost, 0);
    chk(latch, 0);
    cmd(`FCCD_OP_WR_ARM);
    cmd(`FCCD_OP_BOOST);
    cmd(`FCCD_OP_RST_ARM);
    cmd(`FCCD_OP_RST_FIRE);
    chk(boost, 0);
    cmd(`FCCD_OP_WR_ARM);
    cmd(`FCCD_OP_BOOST);
    chk(boost, 1);
    chk(latch, 1);
    hwResetN <= 1'b0;
    repeat (8) @(posedge clk);
    hwResetN <= 1'b1;
    chk(latch, 0);
    chk(boost, 0);
  endtask
  task automatic t_id();
    u_host.frame(`FCCD_OP_ID_QUERY, 1'b0, 8, 24, rd);
    chk(rd, ID);
    chk(soEn, 0);
    u_host.frame(`FCCD_OP_ID_QUERY, 1'b0, 8, 5, rd);
    chk(rd, ID[23:19]);
    clr();
    busy <= 1'b1;
    u_host.frame(`FCCD_OP_ID_QUERY, 1'b0, 8, 8, rd);
    busy <= 1'b0;
    chk(nE, 0);
    quad <= 1'b1;
    u_host.frame(`FCCD_OP_ID_QUERY, 1'b1, 2, 8, rd);
    quad <= 1'b0;
    chk(nE, 0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    t_latch();
    t_content();
    t_reset();
    t_boost();
    t_id();
    conclude();
  end
endmodule
bind fccd_decoder fccd_decoder_checker u_chk (.clk(clk), .sys_rst(sys_rst), .hwResetN(hwResetN),
  .chipSelectN(chipSelectN), .quadCommandMode(quadCommandMode), .pgmEraseBusy(pgmEraseBusy),
  .serialOutEn(serialOutEn), .writeLatch(writeLatch), .boostActive(boostActive),
  .cmdValid(cmdValid), .cmdBoosted(cmdBoosted), .softResetPulse(softResetPulse));
`default_nettype wire
